// ---- cmpc_analog_model.sv ----
// behavioural analog comparator cores and interrupt event counter
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// far-side model
// ----------------------------------------
module cmpc_analog_model (
    input wire logic pclk,
    input wire logic [2:0] unit_enable,
    input wire logic [2:0] positive_input_select,
    input wire logic [2:0][1:0] negative_input_select,
    input wire logic [2:0] unit_event,
    input wire logic [7:0] volt [6],
    output logic [2:0] raw_result,
    output var int evt_cnt [3]
);
    // volt: 0 input a, 1 ladder, 2..4 inputs b..d, 5 absolute reference
    // a switched-off core holds its output low
    always_comb begin
        for (int u = 0; u < 3; u++) begin
            raw_result[u] = unit_enable[u] &&
                ((positive_input_select[u] ? volt[1] : volt[0]) > volt[2 + negative_input_select[u]]);
        end
    end
    // counts high cycles, so a stretched event pulse shows up as extra counts
    initial evt_cnt = '{0, 0, 0};
    always @(posedge pclk) begin
        for (int u = 0; u < 3; u++) begin
            if (unit_event[u] === 1'b1) evt_cnt[u] <= evt_cnt[u] + 1;
        end
    end
endmodule : cmpc_analog_model
`default_nettype wire

// ---- cmpc_consts.svh ----
// constants for the comparator control register block
`ifndef CMPC_CONSTS_SVH
`define CMPC_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CMPC_OFS_CTRL1 16'ha000
`define CMPC_OFS_CTRL2 16'ha010
`define CMPC_OFS_CTRL3 16'ha020
`define CMPC_OFS_STAT 16'ha060
`define CMPC_OFS_IRQ_STAT 16'ha070
`define CMPC_OFS_IRQ_MASK 16'ha080

// ----------------------------------------
// alias codes in address bits 3:2
// ----------------------------------------
`define CMPC_AL_PLAIN 2'h0
`define CMPC_AL_CLR 2'h1
`define CMPC_AL_SET 2'h2
`define CMPC_AL_INV 2'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMPC_BIT_ON 15
`define CMPC_BIT_OE 14
`define CMPC_BIT_INV 13
`define CMPC_BIT_LEVEL 8
`define CMPC_EDGE_HI 7
`define CMPC_EDGE_LO 6
`define CMPC_BIT_POS 4
`define CMPC_NEG_HI 1
`define CMPC_NEG_LO 0
`define CMPC_BIT_HALT 13
`define CMPC_RES_LSB 0

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define CMPC_CTRL_RST 16'h00c3
`define CMPC_STAT_RST 16'h0000
`define CMPC_CTRL_WMASK 16'he0d3
`define CMPC_STAT_WMASK 16'h2000
`define CMPC_IRQ_WMASK 16'h0007

`endif

// ---- cmpc_pkg.sv ----
// types shared by the comparator control block
package cmpc_pkg;

    typedef struct packed {
        logic en;
        logic inv;
        logic [1:0] edge_sel;
    } cmpc_cfg_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic evt;
    } cmpc_unit_s;

    typedef struct packed {
        logic [2:0][15:0] ctrl;
        logic halt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [2:0] en;
        logic [2:0] pin;
        logic [2:0] pin_oe_n;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cmpc_regs_s;

endpackage : cmpc_pkg

// ---- cmpc_top.sv ----
// comparator control and status registers behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_consts.svh"

//Contract
// R01: enable bit 15 toggles unit only
// R02: bit 14 drives result onto pin
// R03: bit 13 inverts the result
// R04: inversion also feeds edge detector
// R05: bit 8 reads current result level
// R06: bits 7:6 pick none/rise/fall/both
// R07: bit 4 picks ladder or input a
// R08: bits 1:0 steer negative input mux
// R09: halt bit stops units in idle
// R10: status bits 2:0 mirror results
// R11: control resets 00c3, status zero
// R12: aliases 4/8/c clear, set, toggle
// R13: software avoids access after disable
// R14: unimplemented bits read zero, ignore writes
// R15: results synchronised; events one-cycle pulses
// R16: disabled unit: no events, no drive
module cmpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic [2:0] raw_result,
    output logic [2:0] unit_enable,
    output logic [2:0] positive_input_select,
    output logic [2:0][1:0] negative_input_select,
    output logic [2:0] result_pin,
    output logic [2:0] result_pin_oe_n,
    output logic [2:0] unit_event,
    output logic irq
);

    // ----------------------------------------
    // address map
    // ----------------------------------------
    localparam logic [15:0] OFS_C1 = `CMPC_OFS_CTRL1;
    localparam logic [15:0] OFS_C2 = `CMPC_OFS_CTRL2;
    localparam logic [15:0] OFS_C3 = `CMPC_OFS_CTRL3;
    localparam logic [15:0] OFS_ST = `CMPC_OFS_STAT;
    localparam logic [15:0] OFS_IS = `CMPC_OFS_IRQ_STAT;
    localparam logic [15:0] OFS_IM = `CMPC_OFS_IRQ_MASK;
    localparam logic [2:0][15:0] OFS_CTRL = {OFS_C3, OFS_C2, OFS_C1};

    cmpc_pkg::cmpc_regs_s q;
    cmpc_pkg::cmpc_regs_s d;
    cmpc_pkg::cmpc_cfg_s [2:0] cfg;
    logic [2:0] lvl;
    logic [2:0] evt;
    logic [2:0] hit_ctrl;
    logic hit_stat;
    logic hit_is;
    logic hit_im;
    logic bad_addr;
    logic [1:0] alias_sel;
    logic setup;
    logic wr;
    logic idle_stop;
    logic [15:0] rdv;
    logic [15:0] stat_wr;

    // ----------------------------------------
    // per-unit decode and comparator logic
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_unit
            assign hit_ctrl[gi] = (paddr[15:4] == OFS_CTRL[gi][15:4]);
            // edge logic sees the gated enable so idle halts events too
            assign cfg[gi].en = q.en[gi];
            assign cfg[gi].inv = q.ctrl[gi][`CMPC_BIT_INV];
            assign cfg[gi].edge_sel = q.ctrl[gi][`CMPC_EDGE_HI:`CMPC_EDGE_LO];

            cmpc_unit u_unit (
                .pclk(pclk),
                .presetn(presetn),
                .raw_result(raw_result[gi]),
                .cfg(cfg[gi]),
                .result_level(lvl[gi]),
                .unit_event(evt[gi])
            );

            assign positive_input_select[gi] = q.ctrl[gi][`CMPC_BIT_POS]; // see R07
            assign negative_input_select[gi] = q.ctrl[gi][`CMPC_NEG_HI:`CMPC_NEG_LO]; // see R08
        end
    endgenerate

    // aliases exist only for the four documented registers
    assign hit_stat = (paddr[15:4] == OFS_ST[15:4]);
    assign hit_is = (paddr == OFS_IS);
    assign hit_im = (paddr == OFS_IM);
    assign alias_sel = paddr[3:2];
    assign bad_addr = (paddr[1:0] != 2'h0) || !(|hit_ctrl || hit_stat || hit_is || hit_im);
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && q.pready && !bad_addr;

    // ----------------------------------------
    // alias write helper
    // ----------------------------------------
    function automatic logic [15:0] cmpc_apply(
        input logic [15:0] old,
        input logic [15:0] w,
        input logic [1:0] al,
        input logic [15:0] m
    );
        logic [15:0] r;
        case (al)
            `CMPC_AL_PLAIN: r = w;
            `CMPC_AL_CLR: r = old & ~w;
            `CMPC_AL_SET: r = old | w;
            default: r = old ^ w;
        endcase
        // only writable bits move, so unimplemented bits stay zero
        return (r & m) | (old & ~m);
    endfunction : cmpc_apply

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rdv = 16'h0000;
        if (hit_ctrl[0]) begin
            rdv = q.ctrl[0];
            rdv[`CMPC_BIT_LEVEL] = lvl[0]; // see R05
        end else if (hit_ctrl[1]) begin
            rdv = q.ctrl[1];
            rdv[`CMPC_BIT_LEVEL] = lvl[1]; // see R05
        end else if (hit_ctrl[2]) begin
            rdv = q.ctrl[2];
            rdv[`CMPC_BIT_LEVEL] = lvl[2]; // see R05
        end else if (hit_stat) begin
            rdv[`CMPC_BIT_HALT] = q.halt;
            rdv[`CMPC_RES_LSB +: 3] = lvl; // see R10
        end else if (hit_is) begin
            rdv[2:0] = q.irq_stat;
        end else if (hit_im) begin
            rdv[2:0] = q.irq_mask;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        idle_stop = q.halt && idle_mode; // see R09

        // registers only change on the access edge with pready high
        for (int i = 0; i < 3; i++) begin
            if (wr && hit_ctrl[i]) begin
                d.ctrl[i] = cmpc_apply(q.ctrl[i], pwdata[15:0], alias_sel, `CMPC_CTRL_WMASK); // see R01 see R12 see R14
            end
        end
        stat_wr = cmpc_apply({2'h0, q.halt, 13'h0000}, pwdata[15:0], alias_sel, `CMPC_STAT_WMASK);
        if (wr && hit_stat) begin
            d.halt = stat_wr[`CMPC_BIT_HALT]; // see R12 see R14
        end
        if (wr && hit_im) begin
            d.irq_mask = pwdata[2:0];
        end

        // write-one-to-clear; a new event in the same cycle wins
        d.irq_stat = q.irq_stat;
        if (wr && hit_is) begin
            d.irq_stat = q.irq_stat & ~pwdata[2:0];
        end
        d.irq_stat = d.irq_stat | evt;
        d.irq = |(d.irq_stat & d.irq_mask);

        // enable gating and pin drive
        for (int i = 0; i < 3; i++) begin
            d.en[i] = d.ctrl[i][`CMPC_BIT_ON] && !idle_stop; // see R01 see R09
            d.pin[i] = lvl[i]; // see R03
            d.pin_oe_n[i] = !(q.en[i] && q.ctrl[i][`CMPC_BIT_OE]); // see R02 see R16
        end

        // read data is captured in setup, answered in the access cycle
        d.pready = setup;
        d.pslverr = setup && bad_addr;
        if (setup) begin
            d.prdata = bad_addr ? 32'h0000_0000 : {16'h0000, rdv}; // see R14
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= {3{`CMPC_CTRL_RST}}; // see R11
            q.halt <= 1'(`CMPC_STAT_RST >> `CMPC_BIT_HALT); // see R11
            q.pin_oe_n <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign unit_enable = q.en;
    assign result_pin = q.pin;
    assign result_pin_oe_n = q.pin_oe_n;
    assign unit_event = evt; // see R15
    assign irq = q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl1_set_write;
        psel && penable && pwrite && pready && paddr == (OFS_C1 | 16'h0008);
    endsequence

    sequence s_ctrl1_inv_write;
        psel && penable && pwrite && pready && paddr == (OFS_C1 | 16'h000c);
    endsequence

    chk_apb_answer: assert property (setup |=> pready ##1 !pready)
        else $error("apb answer not exactly one access cycle");

    chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) // see R14
        else $error("upper half of read data not zero");

    chk_set_alias: assert property (s_ctrl1_set_write |=> // see R12
        q.ctrl[0] == (($past(q.ctrl[0]) | ($past(pwdata[15:0]) & `CMPC_CTRL_WMASK))))
        else $error("set alias did not or in the written ones");

    chk_inv_alias: assert property (s_ctrl1_inv_write |=> // see R12
        q.ctrl[0] == (($past(q.ctrl[0]) ^ ($past(pwdata[15:0]) & `CMPC_CTRL_WMASK))))
        else $error("invert alias did not toggle the written ones");

    chk_on_keeps_rest: assert property ((s_ctrl1_set_write and pwdata[15:0] == 16'h8000) |=> // see R01
        (q.ctrl[0][14:0] == $past(q.ctrl[0][14:0])) && q.ctrl[0][`CMPC_BIT_ON])
        else $error("enable change disturbed other fields");

    chk_idle_halt: assert property ((q.halt && idle_mode) |=> unit_enable == 3'h0 ##1 result_pin_oe_n == 3'h7) // see R09
        else $error("units still run while halted in idle");

    chk_pin_drive: assert property (!result_pin_oe_n[0] |-> ($past(unit_enable[0]) && $past(q.ctrl[0][`CMPC_BIT_OE]))) // see R02
        else $error("pin driven while disabled or not enabled");

    // a clear one cycle later is legal, so the second cycle allows it
    chk_irq_sticky: assert property ((unit_event[0] && !(wr && hit_is)) |=> // see R15
        q.irq_stat[0] ##1 (q.irq_stat[0] || ($past(wr) && $past(hit_is))))
        else $error("event did not set its sticky bit");

    chk_irq_level: assert property (irq == |(q.irq_stat & q.irq_mask))
        else $error("interrupt out of step with status and mask");

    chk_ctrl_reset: assert property ($rose(presetn) |-> q.ctrl[1] == `CMPC_CTRL_RST) // see R11
        else $error("control register reset value wrong");

    // ----------------------------------------
    // register and bus checks
    // ----------------------------------------
    sequence s_ctrl1_clr_write;
        psel && penable && pwrite && pready && paddr == (OFS_C1 | 16'h0004);
    endsequence

    sequence s_ctrl1_plain_write;
        psel && penable && pwrite && pready && paddr == OFS_C1;
    endsequence

    sequence s_ctrl1_read_setup;
        psel && !penable && !pwrite && paddr == OFS_C1;
    endsequence

    sequence s_stat_read_setup;
        psel && !penable && !pwrite && paddr == OFS_ST;
    endsequence

    sequence s_refused_access;
        psel && penable && pready && pslverr;
    endsequence

    chk_clr_alias: assert property (s_ctrl1_clr_write |=> // see R12
        q.ctrl[0] == ($past(q.ctrl[0]) & ~($past(pwdata[15:0]) & `CMPC_CTRL_WMASK)))
        else $error("clear alias did not drop the written ones");

    chk_plain_write: assert property (s_ctrl1_plain_write |=> // see R14
        q.ctrl[0] == ($past(pwdata[15:0]) & `CMPC_CTRL_WMASK))
        else $error("plain write did not land through the writable mask");

    chk_ctrl_unused: assert property ( // see R14
        ((q.ctrl[0] | q.ctrl[1] | q.ctrl[2]) & ~`CMPC_CTRL_WMASK) == 16'h0000)
        else $error("unimplemented control bit holds a one");

    chk_level_read: assert property (s_ctrl1_read_setup |=> // see R05
        prdata[`CMPC_BIT_LEVEL] == $past(lvl[0]))
        else $error("control read did not return the result level");

    chk_status_mirror: assert property (s_stat_read_setup |=> // see R10
        prdata[`CMPC_RES_LSB +: 3] == $past(lvl) && prdata[`CMPC_BIT_HALT] == $past(q.halt))
        else $error("status read did not mirror results and halt bit");

    chk_bad_refused: assert property ((setup && bad_addr) |=> pslverr && prdata == 32'h0000_0000) // see R14
        else $error("unmapped access not refused");

    chk_bad_no_write: assert property (s_refused_access |=> // see R14
        q.ctrl == $past(q.ctrl) && q.halt == $past(q.halt) && q.irq_mask == $past(q.irq_mask))
        else $error("refused access changed a register");

    chk_idle_bus: assert property (!psel |=> !pready && !pslverr)
        else $error("answer without a request");

    // ----------------------------------------
    // unit control and interrupt checks
    // ----------------------------------------
    chk_enable_gate: assert property (unit_enable[0] == // see R01 see R09
        (q.ctrl[0][`CMPC_BIT_ON] && !$past(idle_stop)))
        else $error("unit enable out of step with its control bit");

    chk_pin_value: assert property (result_pin[0] == $past(lvl[0])) // see R03
        else $error("pin value does not follow the result level");

    chk_oe_follows: assert property (result_pin_oe_n[0] == // see R02 see R16
        !($past(unit_enable[0]) && $past(q.ctrl[0][`CMPC_BIT_OE])))
        else $error("pin drive out of step with enable and drive bit");

    chk_event_sets: assert property (unit_event[1] |=> q.irq_stat[1]) // see R15
        else $error("event did not set its status bit");

    chk_clear_works: assert property ((wr && hit_is && pwdata[0] && !unit_event[0]) |=> !q.irq_stat[0])
        else $error("write one did not clear the status bit");

    chk_mask_write: assert property ((wr && hit_im) |=> q.irq_mask == $past(pwdata[2:0]))
        else $error("mask write did not land");

    chk_stat_reset: assert property ($rose(presetn) |-> !q.halt && q.irq_stat == 3'h0) // see R11
        else $error("status reset value wrong");

endmodule : cmpc_top

`default_nettype wire

// ---- cmpc_unit.sv ----
// per-comparator result synchroniser, polarity and edge event logic
`timescale 1ns/1ps
`default_nettype none

module cmpc_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw_result,
    input wire cmpc_pkg::cmpc_cfg_s cfg,
    output logic result_level,
    output logic unit_event
);

    cmpc_pkg::cmpc_unit_s q;
    cmpc_pkg::cmpc_unit_s d;
    logic rise;
    logic fall;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.s1 = raw_result; // see R15
        d.s2 = q.s1;
        d.lvl = q.s2 ^ cfg.inv; // see R03
        // edges are taken after inversion, so they swap with polarity
        rise = d.lvl & ~q.lvl; // see R04
        fall = ~d.lvl & q.lvl;
        d.evt = cfg.en & ((cfg.edge_sel[0] & rise) | (cfg.edge_sel[1] & fall)); // see R06 see R16
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign result_level = q.lvl;
    assign unit_event = q.evt;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [1:0] age_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_sync_two_flop: assert property ((age_q == 2'h3) |-> (q.s2 == $past(raw_result, 2))) // see R15
        else $error("result not synchronised through two flops");
    chk_rise_only: assert property ((q.evt && $past(cfg.edge_sel) == 2'b01) |-> (q.lvl && !$past(q.lvl))) // see R06
        else $error("rising event without a rising edge");
    chk_fall_only: assert property ((q.evt && $past(cfg.edge_sel) == 2'b10) |-> (!q.lvl && $past(q.lvl))) // see R06
        else $error("falling event without a falling edge");
    chk_event_off: assert property (q.evt |-> ($past(cfg.en) && $past(cfg.edge_sel) != 2'b00)) // see R16
        else $error("event while disabled");
    chk_event_pulse: assert property (q.evt |=> !q.evt) // see R15
        else $error("event longer than one cycle");

endmodule : cmpc_unit

`default_nettype wire

// ---- tb_comparator_control_regs.sv ----
// self-checking bench for the comparator control registers
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// bench top
// ----------------------------------------
module tb_comparator_control_regs;
    typedef struct {logic [15:0] wa; logic [15:0] ra; logic [31:0] wd; logic [31:0] exp; logic err;} cmpc_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic idle_mode = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [2:0] raw_result, unit_enable, positive_input_select, result_pin, result_pin_oe_n, unit_event;
    logic [2:0][1:0] negative_input_select;
    logic [7:0] volt [6] = '{default: 8'h00};
    int evt_cnt [3];
    int error_cnt = 0;
    int samples_checked = 0;
    int base;
    logic [31:0] rd;
    logic er;
    // alias writes read back through the base address
    cmpc_row_s rows [11] = '{
        '{16'ha000, 16'ha000, 32'hffffffff, 32'h0000e1d3, 1'b0},
        '{16'ha004, 16'ha000, 32'h00006000, 32'h000080d3, 1'b0},
        '{16'ha008, 16'ha000, 32'h00002010, 32'h0000a1d3, 1'b0},
        '{16'ha00c, 16'ha000, 32'h000020c3, 32'h00008010, 1'b0},
        '{16'ha010, 16'ha010, 32'h00001e20, 32'h00000000, 1'b0},
        '{16'ha020, 16'ha020, 32'hffff4081, 32'h00004081, 1'b0},
        '{16'ha060, 16'ha060, 32'hffffffff, 32'h00002000, 1'b0},
        '{16'ha064, 16'ha060, 32'h00002000, 32'h00000000, 1'b0},
        '{16'ha06c, 16'ha060, 32'h00002000, 32'h00002000, 1'b0},
        '{16'ha080, 16'ha080, 32'hffffffff, 32'h00000007, 1'b0},
        '{16'ha040, 16'ha040, 32'h0000ffff, 32'h00000000, 1'b1}
    };

    cmpc_top cmpc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .idle_mode, .raw_result, .unit_enable, .positive_input_select, .negative_input_select,
        .result_pin, .result_pin_oe_n, .unit_event, .irq);
    cmpc_analog_model cmpc_analog_model_i (.pclk, .unit_enable, .positive_input_select,
        .negative_input_select, .unit_event, .volt, .raw_result, .evt_cnt);

    always #25 pclk = ~pclk;

    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        samples_checked++;
        if (act !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, act);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // one transfer, then one idle edge so the next setup never lands on the release edge
    task automatic apb(input logic [15:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        apb(a, 32'h00000000, 1'b0);
        chk(exp, rd);
    endtask : rdchk

    task automatic reset_check();
        presetn <= 1'b0;
        tick(20);
        chk(32'h00071f80, {13'h0, result_pin_oe_n, positive_input_select, negative_input_select, irq,
            unit_enable, unit_event});
        presetn <= 1'b1;
        tick(1);
        for (int u = 0; u < 3; u++) rdchk(16'ha000 + 16'(u * 16), 32'h000000c3);
        rdchk(16'ha060, 32'h00000000);
        $display("test reset done");
    endtask : reset_check

    initial begin
        reset_check();
        for (int i = 0; i < 11; i++) begin
            apb(rows[i].wa, rows[i].wd, 1'b1);
            tick(4);
            apb(rows[i].ra, 32'h00000000, 1'b0);
            chk(rows[i].exp, rd);
            chk({31'h0, rows[i].err}, {31'h0, er});
        end
        $display("test table done");
        apb(16'ha000, 32'h00008040, 1'b1);
        tick(4);
        apb(16'ha070, 32'h00000007, 1'b1);
        base = evt_cnt[0];
        volt[0] <= 8'h0a;
        tick(6);
        rdchk(16'ha060, 32'h00002001);
        rdchk(16'ha000, 32'h00008140);
        chk(32'h00000007, {29'h0, result_pin[0], result_pin_oe_n[0], irq});
        chk(32'h00000001, evt_cnt[0] - base);
        apb(16'ha008, 32'h00004000, 1'b1);
        tick(3);
        chk(32'h00000000, {31'h0, result_pin_oe_n[0]});
        apb(16'ha008, 32'h00002000, 1'b1);
        tick(6);
        chk(32'h00000000, {31'h0, result_pin[0]});
        volt[0] <= 8'h00;
        tick(6);
        chk(32'h00000002, evt_cnt[0] - base);
        apb(16'ha070, 32'h00000001, 1'b1);
        tick(2);
        chk(32'h00000000, {31'h0, irq});
        rdchk(16'ha070, 32'h00000000);
        $display("test events done");
        for (int v = 2; v < 6; v++) volt[v] <= 8'h05;
        for (int i = 0; i < 4; i++) begin
            apb(16'ha010, 32'h00008010 | 32'(i * 65), 1'b1);
            tick(4);
            chk(32'h0000000c | 32'(i),
                {28'h0, unit_enable[1], positive_input_select[1], negative_input_select[1]});
            base = evt_cnt[1];
            volt[1] <= 8'h0a;
            tick(6);
            volt[1] <= 8'h00;
            tick(6);
            chk(32'($countones(i)), evt_cnt[1] - base);
        end
        $display("test edge codes done");
        idle_mode <= 1'b1;
        tick(4);
        chk(32'h00000001, {28'h0, unit_enable, result_pin_oe_n[0]});
        rdchk(16'ha000, 32'h0000e140);
        idle_mode <= 1'b0;
        tick(4);
        chk(32'h00000003, {29'h0, unit_enable});
        apb(16'ha004, 32'h00008000, 1'b1);
        tick(3);
        rdchk(16'ha000, 32'h00006140);
        chk(32'h00000005, {28'h0, unit_enable, result_pin_oe_n[0]});
        // set alias on the enable bit alone must leave every other field as it was
        apb(16'ha008, 32'h00008000, 1'b1);
        tick(3);
        rdchk(16'ha000, 32'h0000e140);
        chk(32'h00000003, {29'h0, unit_enable});
        $display("test idle done");
        for (int v = 0; v < 6; v++) volt[v] <= 8'h00;
        reset_check();
        complete_run();
    end
endmodule : tb_comparator_control_regs
`default_nettype wire
